// *** src/csl_pkg.sv ***
// shared constants and types for the core sequencer latency control block
// assumes one core clock; every clock edge is one instruction cycle
package csl_pkg;

	// system register count and select codes
	localparam int CSL_NUM_SREG = 16;
	localparam logic [3:0] CSL_SREG_PRIMARY_MODE_REGISTER = 4'h0;
	localparam logic [3:0] CSL_SREG_SECONDARY_MODE_REGISTER = 4'h1;
	localparam logic [3:0] CSL_SREG_INTERRUPT_LATCH_REGISTER = 4'h2;
	localparam logic [3:0] CSL_SREG_LOW_INTERRUPT_LATCH_REGISTER = 4'h3;
	localparam logic [3:0] CSL_SREG_INTERRUPT_MASK_REGISTER = 4'h4;
	localparam logic [3:0] CSL_SREG_INTERRUPT_MASK_POINTER = 4'h5;
	localparam logic [3:0] CSL_SREG_MODE_MASK_REGISTER = 4'h6;
	localparam logic [3:0] CSL_SREG_FLAGS = 4'h7;
	localparam logic [3:0] CSL_SREG_ASTAT_PRI = 4'h8;
	localparam logic [3:0] CSL_SREG_ASTAT_SEC = 4'h9;
	localparam logic [3:0] CSL_SREG_STKY_PRI = 4'hA;
	localparam logic [3:0] CSL_SREG_STKY_SEC = 4'hB;
	localparam logic [3:0] CSL_SREG_USER_STATUS_ONE = 4'hC;
	localparam logic [3:0] CSL_SREG_USER_STATUS_TWO = 4'hD;
	localparam logic [3:0] CSL_SREG_USER_STATUS_THREE = 4'hE;
	localparam logic [3:0] CSL_SREG_USER_STATUS_FOUR = 4'hF;
	localparam logic [31:0] CSL_SREG_RESET = 32'h0000_0000;

	// bit positions inside the primary mode register
	localparam int CSL_BIT_SEC_SELECT = 6;
	localparam int CSL_BIT_BIT_REVERSE = 1;
	localparam int CSL_BIT_SIMD = 21;

	// interrupt level that belongs to the vector interrupt
	localparam logic [4:0] CSL_VEC_LEVEL = 5'h0A;

	// register bus map
	localparam logic [7:0] CSL_OFF_VEC_ADDR = 8'h00;
	localparam logic [7:0] CSL_OFF_STATUS = 8'h04;
	localparam logic [7:0] CSL_OFF_DAG_CTRL = 8'h08;
	localparam logic [1:0] CSL_SREG_WINDOW = 2'h1;
	localparam logic [31:0] CSL_VEC_ADDR_RESET = 32'h0000_0000;
	localparam int CSL_STAT_VEC_PEND = 0;
	localparam int CSL_STAT_VEC_SERV = 1;
	localparam int CSL_STAT_LOOP_RUN = 2;
	localparam int CSL_STAT_DAG_SEC = 3;
	localparam int CSL_STAT_SIMD = 4;

	// single-instruction loop tail after the exit condition
	localparam logic [1:0] CSL_LOOP_TAIL = 2'h3;

	// DAG index register count
	localparam int CSL_NUM_IDX = 8;

	typedef enum logic [1:0] {
		CSL_OP_LOAD,
		CSL_OP_SET,
		CSL_OP_CLR,
		CSL_OP_TGL
	} csl_op_e;

	typedef enum logic [1:0] {
		CSL_LOOP_IDLE,
		CSL_LOOP_RUN,
		CSL_LOOP_DRAIN
	} csl_loop_e;

endpackage

// *** src/csl_dly_reg.sv ***
// one system register with a one-cycle effect latency
// assumes writes come from same-clock decode logic
module csl_dly_reg
	import csl_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// write from an instruction
	input wire logic wrEn,
	input wire logic [1:0] wrOp,
	input wire logic [31:0] wrData,
	// immediate hardware clear
	input wire logic [31:0] hwClr,
	// effective value
	output logic [31:0] value
);

	typedef struct packed {
		logic pendValid;
		logic [31:0] pendData;
		logic [31:0] value;
	} csl_dly_s;

	csl_dly_s state_reg;
	csl_dly_s state_next;

	always_comb begin
		logic [31:0] base;
		base = state_reg.pendValid ? state_reg.pendData : state_reg.value;
		state_next = state_reg;
		// pending data lands one cycle after the write
		state_next.value = base & ~hwClr;
		state_next.pendValid = 1'b0;
		if (wrEn) begin
			state_next.pendValid = 1'b1;
			case (csl_op_e'(wrOp))
				CSL_OP_LOAD: state_next.pendData = wrData;
				CSL_OP_SET: state_next.pendData = base | wrData;
				CSL_OP_CLR: state_next.pendData = base & ~wrData;
				CSL_OP_TGL: state_next.pendData = base ^ wrData;
				default: state_next.pendData = wrData;
			endcase
			state_next.pendData = state_next.pendData & ~hwClr;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= '{pendValid: 1'b0, pendData: CSL_SREG_RESET, value: CSL_SREG_RESET};
		end else begin
			state_reg <= state_next;
		end
	end

	assign value = state_reg.value;

endmodule

// *** src/csl_core_seq.sv ***
// core sequencer latency control: system register latency, DAG context,
// conditional return, single-instruction loop tail, bit-reversed jump,
// vector interrupt pending flag
// assumes decode, DAG, stack and interrupt logic on the same core clock
//
// Functional notes
// - DAG bank switch takes effect one cycle late
// - read after switch uses secondary, no forwarding
// - system register writes effective one cycle later
// - latency covers all sixteen system registers
// - dual-mode return needs both conditions true
// - return branches, pops status if pushed, clears mask bit
// - false in either element: no return action
// - loop exits after three iterations past condition
// - bit-reverse mode reverses indirect jump index
// - vector pending flag clears only on return
//
// The address map and strobed register access are this design's own decisions.
module csl_core_seq
	import csl_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// register bus
	input wire logic [7:0] busAddr,
	input wire logic [31:0] busWrData,
	input wire logic busWr,
	input wire logic busRd,
	output logic [31:0] busRdData,
	// system register write from decode (pm, dm or bit op alike)
	input wire logic sregWr,
	input wire logic [3:0] sregSel,
	input wire logic [1:0] sregOp,
	input wire logic [31:0] sregData,
	output logic [31:0] primaryModeEff,
	// DATA_ADDRESS_GENERATOR_ONE index registers
	input wire logic dagWr,
	input wire logic [2:0] dagWrIdx,
	input wire logic [31:0] dagWrData,
	input wire logic dagRd,
	input wire logic [2:0] dagRdIdx,
	output logic [31:0] dagRdData,
	output logic dagSecSel,
	// conditional return from interrupt
	input wire logic rtiReq,
	input wire logic rtiCondPri,
	input wire logic rtiCondSec,
	input wire logic rtiStatusPushed,
	input wire logic [4:0] rtiLevel,
	input wire logic [31:0] pcStackTop,
	output logic statusPop,
	// indirect jump
	input wire logic jumpReq,
	input wire logic [31:0] jumpIndex,
	input wire logic [31:0] jumpModify,
	// branch result
	output logic branchValid,
	output logic [31:0] branchTarget,
	// single-instruction loop
	input wire logic loopStart,
	input wire logic loopCondMet,
	output logic loopRun,
	output logic loopDone,
	// vector interrupt
	input wire logic vecEnter,
	output logic vecPending,
	output logic vecInService,
	output logic [31:0] vecAddr
);

	typedef struct packed {
		logic [CSL_NUM_IDX-1:0][31:0] idxPri;
		logic [CSL_NUM_IDX-1:0][31:0] idxSec;
		logic [31:0] dagRdData;
		logic branchValid;
		logic [31:0] branchTarget;
		logic statusPop;
		csl_loop_e loopState;
		logic [1:0] loopCnt;
		logic loopRun;
		logic loopDone;
		logic [31:0] vecAddr;
		logic vecPending;
		logic vecInService;
		logic dagLock;
		logic [31:0] busRdData;
	} csl_top_s;

	csl_top_s state_reg;
	csl_top_s state_next;

	logic [CSL_NUM_SREG-1:0][31:0] sregVal;
	logic [CSL_NUM_SREG-1:0] sregWrEn;
	logic [CSL_NUM_SREG-1:0][31:0] sregHwClr;
	logic [1:0] sregWrOp;
	logic [31:0] sregWrData;
	logic [3:0] sregWrSel;
	logic sregWrAny;
	logic busSregHit;
	logic secSelEff;
	logic simdEff;
	logic bitRevEff;
	logic rtiCond;
	logic rtiExec;
	logic [31:0] jumpBase;

	// bus writes to the system register window share the decode path;
	// decode has priority, a colliding bus write is dropped
	assign busSregHit = busAddr[7:6] == CSL_SREG_WINDOW;
	assign sregWrAny = sregWr || (busWr && busSregHit);
	assign sregWrSel = sregWr ? sregSel : busAddr[5:2];
	assign sregWrOp = sregWr ? sregOp : CSL_OP_LOAD;
	assign sregWrData = sregWr ? sregData : busWrData;

	// mode bits are read from the effective (already latent) value
	assign secSelEff = sregVal[CSL_SREG_PRIMARY_MODE_REGISTER][CSL_BIT_SEC_SELECT];
	assign simdEff = sregVal[CSL_SREG_PRIMARY_MODE_REGISTER][CSL_BIT_SIMD];
	assign bitRevEff = sregVal[CSL_SREG_PRIMARY_MODE_REGISTER][CSL_BIT_BIT_REVERSE];

	// dual mode demands both elements; single mode only the primary
	assign rtiCond = rtiCondPri && (!simdEff || rtiCondSec);
	assign rtiExec = rtiReq && rtiCond;

	// full 32-bit reversal of the index before modify
	always_comb begin
		jumpBase = jumpIndex;
		if (bitRevEff) begin
			for (int b = 0; b < 32; b++) begin
				jumpBase[b] = jumpIndex[31-b];
			end
		end
	end

	// one latent register per system register
	generate
		for (genvar g = 0; g < CSL_NUM_SREG; g++) begin : g_sreg
			always_comb begin
				sregWrEn[g] = sregWrAny && (sregWrSel == 4'(g));
				sregHwClr[g] = 32'h0000_0000;
				if ((4'(g) == CSL_SREG_INTERRUPT_MASK_POINTER) && rtiExec) begin
					sregHwClr[g] = 32'h0000_0001 << rtiLevel;
				end
			end
			csl_dly_reg u_reg (
				.mclk(mclk),
				.rst_b(rst_b),
				.wrEn(sregWrEn[g]),
				.wrOp(sregWrOp),
				.wrData(sregWrData),
				.hwClr(sregHwClr[g]),
				.value(sregVal[g])
			);
		end
	endgenerate

	always_comb begin
		state_next = state_reg;
		state_next.branchValid = 1'b0;
		state_next.statusPop = 1'b0;
		state_next.loopDone = 1'b0;
		state_next.busRdData = 32'h0000_0000;

		// DAG index bank: bank chosen by the effective select, reads come
		// from stored state only so a same-slot write is never forwarded
		if (dagWr) begin
			if (secSelEff) begin
				state_next.idxSec[dagWrIdx] = dagWrData;
			end else begin
				state_next.idxPri[dagWrIdx] = dagWrData;
			end
		end
		if (dagRd) begin
			state_next.dagRdData = secSelEff ? state_reg.idxSec[dagRdIdx] :
				state_reg.idxPri[dagRdIdx];
		end

		// branch: return wins over an indirect jump in the same cycle
		if (rtiExec) begin
			state_next.branchValid = 1'b1;
			state_next.branchTarget = pcStackTop;
			state_next.statusPop = rtiStatusPushed;
		end else if (jumpReq) begin
			state_next.branchValid = 1'b1;
			state_next.branchTarget = jumpBase + jumpModify;
		end

		// single-instruction loop, pm or dm instruction alike
		case (state_reg.loopState)
			CSL_LOOP_IDLE: begin
				if (loopStart) begin
					state_next.loopState = CSL_LOOP_RUN;
					state_next.loopRun = 1'b1;
				end
			end
			CSL_LOOP_RUN: begin
				// condition sampled every cycle
				if (loopCondMet) begin
					state_next.loopState = CSL_LOOP_DRAIN;
					state_next.loopCnt = 2'h0;
				end
			end
			CSL_LOOP_DRAIN: begin
				state_next.loopCnt = state_reg.loopCnt + 2'h1;
				if (state_reg.loopCnt == CSL_LOOP_TAIL - 2'h1) begin
					state_next.loopState = CSL_LOOP_IDLE;
					state_next.loopRun = 1'b0;
					state_next.loopDone = 1'b1;
				end
			end
			default: begin
				state_next.loopState = CSL_LOOP_IDLE;
				state_next.loopRun = 1'b0;
			end
		endcase

		// vector interrupt: entry keeps the flag, return clears it
		if (vecEnter && state_reg.vecPending) begin
			state_next.vecInService = 1'b1;
		end
		if (rtiExec && (rtiLevel == CSL_VEC_LEVEL) && state_reg.vecInService) begin
			state_next.vecPending = 1'b0;
			state_next.vecInService = 1'b0;
		end
		// a new address always lands; the host is expected to poll first,
		// and a set in the clearing cycle wins
		if (busWr && (busAddr == CSL_OFF_VEC_ADDR)) begin
			state_next.vecAddr = busWrData;
			state_next.vecPending = 1'b1;
		end

		// dag lock: software may hold the secondary bank read-only
		if (busWr && (busAddr == CSL_OFF_DAG_CTRL)) begin
			state_next.dagLock = busWrData[0];
		end
		if (dagWr && secSelEff && state_reg.dagLock) begin
			state_next.idxSec[dagWrIdx] = state_reg.idxSec[dagWrIdx];
		end

		// read data appears the cycle after the strobe, zero elsewhere
		if (busRd) begin
			if (busSregHit) begin
				state_next.busRdData = sregVal[busAddr[5:2]];
			end else if (busAddr == CSL_OFF_VEC_ADDR) begin
				state_next.busRdData = state_reg.vecAddr;
			end else if (busAddr == CSL_OFF_STATUS) begin
				state_next.busRdData[CSL_STAT_VEC_PEND] = state_reg.vecPending;
				state_next.busRdData[CSL_STAT_VEC_SERV] = state_reg.vecInService;
				state_next.busRdData[CSL_STAT_LOOP_RUN] = state_reg.loopRun;
				state_next.busRdData[CSL_STAT_DAG_SEC] = secSelEff;
				state_next.busRdData[CSL_STAT_SIMD] = simdEff;
			end else if (busAddr == CSL_OFF_DAG_CTRL) begin
				state_next.busRdData[0] = state_reg.dagLock;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= '0;
			state_reg.loopState <= CSL_LOOP_IDLE;
			state_reg.vecAddr <= CSL_VEC_ADDR_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign busRdData = state_reg.busRdData;
	assign primaryModeEff = sregVal[CSL_SREG_PRIMARY_MODE_REGISTER];
	assign dagRdData = state_reg.dagRdData;
	assign dagSecSel = secSelEff;
	assign statusPop = state_reg.statusPop;
	assign branchValid = state_reg.branchValid;
	assign branchTarget = state_reg.branchTarget;
	assign loopRun = state_reg.loopRun;
	assign loopDone = state_reg.loopDone;
	assign vecPending = state_reg.vecPending;
	assign vecInService = state_reg.vecInService;
	assign vecAddr = state_reg.vecAddr;

endmodule

// *** testbench/csl_core_seq_asserts.sv ***
// port-level checker for csl_core_seq
// assumes one core clock and the async active-low reset of the block
module csl_core_seq_asserts
	import csl_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// system registers
	input wire logic busWr,
	input wire logic sregWr,
	input wire logic [3:0] sregSel,
	input wire logic [1:0] sregOp,
	input wire logic [31:0] sregData,
	input wire logic [31:0] primaryModeEff,
	input wire logic dagSecSel,
	// return and jump
	input wire logic rtiReq,
	input wire logic rtiCondPri,
	input wire logic rtiCondSec,
	input wire logic rtiStatusPushed,
	input wire logic [4:0] rtiLevel,
	input wire logic [31:0] pcStackTop,
	input wire logic statusPop,
	input wire logic jumpReq,
	input wire logic [31:0] jumpIndex,
	input wire logic [31:0] jumpModify,
	input wire logic branchValid,
	input wire logic [31:0] branchTarget,
	// loop and vector
	input wire logic loopRun,
	input wire logic loopCondMet,
	input wire logic loopDone,
	input wire logic vecEnter,
	input wire logic vecPending,
	input wire logic vecInService
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	logic simd;
	assign simd = primaryModeEff[CSL_BIT_SIMD];
	function automatic logic [31:0] rev(input logic [31:0] v);
		for (int k = 0; k < 32; k++)
			rev[k] = v[31 - k];
	endfunction
	load_late_a: assert property (
		sregWr && sregSel == CSL_SREG_PRIMARY_MODE_REGISTER && sregOp == CSL_OP_LOAD ##1 !sregWr && !busWr
		|=> primaryModeEff == $past(sregData, 2)) else $error("mode load not seen on time");
	hold_old_a: assert property (
		!$past(sregWr) && !$past(busWr) && sregWr && sregSel == CSL_SREG_PRIMARY_MODE_REGISTER
		|=> $stable(primaryModeEff)) else $error("mode write took effect early");
	switch_late_a: assert property (
		$rose(dagSecSel) |-> $past(sregWr, 2) || $past(busWr, 2))
		else $error("bank switch without earlier write");
	rti_skip_a: assert property (
		rtiReq && !jumpReq && simd && !(rtiCondPri && rtiCondSec)
		|=> !branchValid && !statusPop) else $error("false return acted");
	rti_take_a: assert property (
		rtiReq && rtiCondPri && (!simd || rtiCondSec) |=> branchValid
		&& branchTarget == $past(pcStackTop) && statusPop == $past(rtiStatusPushed))
		else $error("return did not act");
	jump_rev_a: assert property (
		jumpReq && !rtiReq && primaryModeEff[CSL_BIT_BIT_REVERSE] |=> branchValid
		&& branchTarget == rev($past(jumpIndex)) + $past(jumpModify))
		else $error("jump target not reversed");
	loop_tail_a: assert property (
		loopRun && $rose(loopCondMet) |=> loopRun [*3] ##1 (!loopRun && loopDone))
		else $error("loop tail length wrong");
	vec_hold_a: assert property (
		vecPending && !(rtiReq && rtiCondPri && rtiLevel == CSL_VEC_LEVEL) |=> vecPending)
		else $error("vector pending dropped early");
	vec_enter_a: assert property (
		vecEnter && vecPending |=> vecPending && vecInService)
		else $error("vector entry cleared pending");
endmodule

bind csl_core_seq csl_core_seq_asserts chk (.*);

// *** testbench/csl_core_seq_tb.sv ***
// self-checking bench for csl_core_seq
// assumes the checker binds itself; strobes go out through one staging vector
module csl_core_seq_tb
	import csl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0, rst_b = 1'b0, rdP = 1'b0, dgP = 1'b0;
	logic busWr, busRd, sregWr, dagWr, dagRd, rtiReq, jumpReq, loopStart, vecEnter;
	logic rtiCondPri, rtiCondSec, rtiStatusPushed, loopCondMet, dagSecSel, statusPop;
	logic branchValid, loopRun, loopDone, vecPending, vecInService;
	logic [7:0] busAddr, ad;
	logic [3:0] sregSel;
	logic [1:0] sregOp;
	logic [2:0] dagWrIdx, dagRdIdx;
	logic [4:0] rtiLevel;
	logic [31:0] busWrData, busRdData, sregData, primaryModeEff, dagWrData, dagRdData;
	logic [31:0] pcStackTop, jumpIndex, jumpModify, branchTarget, vecAddr, a, m;
	logic [8:0] st;
	logic [32:0] rdQ[$], dgQ[$], brQ[$];
	int error_cnt = 0, compares = 0, seed = 53, i;

	csl_core_seq dut (.*);

	always #10 mclk = ~mclk;

	function automatic logic [31:0] rev(input logic [31:0] v);
		for (int k = 0; k < 32; k++)
			rev[k] = v[31 - k];
	endfunction
	// strobes change once per edge, so a pulse never collides with the next one
	task automatic step();
		{sregWr, dagWr, dagRd, busRd, busWr, rtiReq, jumpReq, loopStart, vecEnter} <= st;
		st = 9'h000;
		@(posedge mclk);
	endtask
	task automatic cmp(input logic [32:0] g, input logic [32:0] e);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic take(input logic [32:0] g, ref logic [32:0] q[$]);
		logic [32:0] e;
		e = (q.size() > 0) ? q.pop_front() : 33'hX;
		cmp(g, e);
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		busAddr <= ad;
		st[5] = 1'b1;
		rdQ.push_back({1'b0, e});
		step();
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		busAddr <= ad;
		busWrData <= d;
		st[4] = 1'b1;
		step();
	endtask
	task automatic sw(input logic [1:0] op, input logic [3:0] s, input logic [31:0] d);
		sregOp <= op;
		sregSel <= s;
		sregData <= d;
		st[8] = 1'b1;
	endtask
	task automatic md(input logic [1:0] op, input logic [31:0] d, input int n);
		sw(op, CSL_SREG_PRIMARY_MODE_REGISTER, d);
		repeat (n) step();
	endtask
	task automatic dg(input logic w, input logic [31:0] d);
		dagWrIdx <= 3'h2;
		dagRdIdx <= 3'h2;
		dagWrData <= d;
		st[7] = w;
		st[6] = !w;
		if (!w)
			dgQ.push_back({1'b0, d});
		step();
	endtask
	task automatic rst();
		step();
		rst_b <= 1'b0;
		repeat (10) step();
		rst_b <= 1'b1;
		step();
	endtask
	task automatic finish_test();
		// a result that never showed up is as bad as a wrong one
		if (rdQ.size() + dgQ.size() + brQ.size() != 0) begin
			error_cnt++;
			$display("CHECK FAILED %0t expected results never appeared", $time);
		end
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// results are matched to the oldest expectation of their kind
	always @(posedge mclk) begin
		if (rdP)
			take({1'b0, busRdData}, rdQ);
		if (dgP)
			take({1'b0, dagRdData}, dgQ);
		if (branchValid)
			take({statusPop, branchTarget}, brQ);
		rdP <= busRd;
		dgP <= dagRd;
	end

	initial begin
		repeat (2000) @(posedge mclk);
		error_cnt++;
		finish_test();
	end

	initial begin
		{busAddr, busWrData, sregSel, sregOp, sregData, dagWrIdx, dagWrData, dagRdIdx} = '0;
		{rtiCondPri, rtiCondSec, rtiStatusPushed, rtiLevel, pcStackTop} = '0;
		{jumpIndex, jumpModify, loopCondMet, st} = '0;
		rst();
		// mode bits masked so the later tests start from a known mode
		for (i = 0; i < 16; i++) begin
			a = $random(seed) & ((i == 0) ? 32'hFFDF_FFBD : 32'hFFFF_FFFF);
			m = $random(seed) & ((i == 0) ? 32'hFFDF_FFBD : 32'hFFFF_FFFF);
			ad = 8'h40 + 8'(i * 4);
			sw(CSL_OP_LOAD, i[3:0], a);
			step();
			sw(CSL_OP_TGL, i[3:0], m);
			rd(ad, CSL_SREG_RESET);
			rd(ad, a);
			rd(ad, a ^ m);
		end
		$display("system register test done");
		rst();
		md(CSL_OP_SET, 32'h0000_0040, 2);
		dg(1'b1, 32'h0000_00AA);
		md(CSL_OP_CLR, 32'h0000_0040, 2);
		md(CSL_OP_SET, 32'h0000_0040, 1);
		cmp({32'h0, dagSecSel}, {32'h0, 1'b0});
		dg(1'b1, 32'h0000_0052);
		dg(1'b0, 32'h0000_00AA);
		cmp({32'h0, dagSecSel}, {32'h0, 1'b1});
		md(CSL_OP_CLR, 32'h0000_0040, 2);
		dg(1'b0, 32'h0000_0052);
		$display("bank switch test done");
		for (i = 0; i < 8; i++) begin
			if (i == 4)
				md(CSL_OP_LOAD, 32'h0000_0002, 2);
			a = (i == 4) ? 32'h0000_A400 : $random(seed);
			m = $random(seed);
			jumpIndex <= a;
			jumpModify <= m;
			st[2] = 1'b1;
			brQ.push_back({1'b0, ((i < 4) ? a : rev(a)) + m});
			step();
		end
		md(CSL_OP_LOAD, 32'h0000_0000, 2);
		$display("jump test done");
		sw(CSL_OP_LOAD, CSL_SREG_INTERRUPT_MASK_POINTER, 32'h0000_0008);
		step();
		md(CSL_OP_LOAD, 32'h0020_0000, 2);
		rtiLevel <= 5'h03;
		for (i = 0; i < 4; i++) begin
			a = $random(seed);
			rtiCondPri <= i[0];
			rtiCondSec <= i[1];
			rtiStatusPushed <= i[0];
			pcStackTop <= a;
			st[3] = 1'b1;
			if (i == 3)
				brQ.push_back({1'b1, a});
			step();
			rd(8'h54, (i == 3) ? 32'h0000_0000 : 32'h0000_0008);
		end
		md(CSL_OP_LOAD, 32'h0000_0000, 2);
		$display("return test done");
		st[1] = 1'b1;
		repeat (3) step();
		loopCondMet <= 1'b1;
		step();
		for (i = 1; i < 5; i++) begin
			#1 cmp({31'h0, loopRun, loopDone}, {31'h0, i < 4, i == 4});
			@(posedge mclk);
		end
		loopCondMet <= 1'b0;
		$display("loop test done");
		a = $random(seed);
		// host polls for a finished vector before posting a new address
		rd(CSL_OFF_STATUS, 32'h0000_0000);
		wr(CSL_OFF_VEC_ADDR, a);
		rd(CSL_OFF_VEC_ADDR, a);
		cmp({1'b0, vecAddr}, {1'b0, a});
		rd(CSL_OFF_STATUS, 32'h0000_0001);
		st[0] = 1'b1;
		step();
		rd(CSL_OFF_STATUS, 32'h0000_0003);
		rtiLevel <= CSL_VEC_LEVEL;
		rtiCondPri <= 1'b1;
		rtiCondSec <= 1'b0;
		rtiStatusPushed <= 1'b0;
		pcStackTop <= a;
		st[3] = 1'b1;
		brQ.push_back({1'b0, a});
		step();
		rd(CSL_OFF_STATUS, 32'h0000_0000);
		rd(8'h0C, 32'h0000_0000);
		$display("vector test done");
		// bus path into the system register window keeps the same latency
		wr({CSL_SREG_WINDOW, CSL_SREG_USER_STATUS_ONE, 2'b00}, a);
		rd({CSL_SREG_WINDOW, CSL_SREG_USER_STATUS_ONE, 2'b00}, CSL_SREG_RESET);
		rd({CSL_SREG_WINDOW, CSL_SREG_USER_STATUS_ONE, 2'b00}, a);
		// locked secondary bank must ignore the write
		wr(CSL_OFF_DAG_CTRL, 32'h0000_0001);
		md(CSL_OP_SET, 32'h0000_0040, 2);
		dg(1'b1, 32'h0000_0033);
		dg(1'b0, 32'h0000_00AA);
		rd(CSL_OFF_DAG_CTRL, 32'h0000_0001);
		md(CSL_OP_CLR, 32'h0000_0040, 2);
		repeat (2) step();
		$display("bus window and lock test done");
		finish_test();
	end
endmodule
